// *** design/sdm_pkg.sv ***
// Package with register map, function codes and sample layout constants
package sdm_pkg;
  // Bus geometry: byte address = 4 * register index
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int IDX_LSB = 2;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_LINE0_FUNCTION_SELECT = 16'hB860;
  localparam logic [IDX_W-1:0] IDX_LINE1_FUNCTION_SELECT = 16'hB861;
  localparam logic [IDX_W-1:0] IDX_LINE2_FUNCTION_SELECT = 16'hB862;
  localparam logic [IDX_W-1:0] IDX_LINE0_SUPPORTED_FUNCTIONS = 16'hB86A;
  localparam logic [IDX_W-1:0] IDX_LINE1_SUPPORTED_FUNCTIONS = 16'hB86B;
  localparam logic [IDX_W-1:0] IDX_LINE2_SUPPORTED_FUNCTIONS = 16'hB86C;
  localparam logic [IDX_W-1:0] IDX_CARD_COMMAND = 16'hB870;
  localparam logic [IDX_W-1:0] IDX_ASYNC_LINE_LEVELS = 16'hB871;
  localparam logic [IDX_W-1:0] IDX_MERGE_STATUS = 16'hB872;

  // Card command register bits (write one to issue)
  localparam int CMD_CARD_START_BIT = 0;
  localparam int CMD_WRITE_SETUP_BIT = 1;

  // Function codes
  localparam logic [31:0] FUNCTION_NONE = 32'h00000000;
  localparam logic [31:0] FUNCTION_SYNC_DIGITAL_IN = 32'h00000004;
  localparam logic [31:0] SELECT_RESET = FUNCTION_NONE;
  localparam logic [31:0] SUPPORTED_DEFAULT = FUNCTION_SYNC_DIGITAL_IN;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sample layout
  localparam int NUM_LINES = 3;
  localparam int SAMPLE_W = 8;
  localparam int DIGITAL_BIT = 7;
  localparam int ANALOG_DROP = 1;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_STAGES = 3;
endpackage : sdm_pkg

// *** design/sdm_merge.sv ***
// Sync digital input merge: line function registers, AXI4-Lite slave, sample merge, FIFO
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

module sdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0] wr_ptr;
  logic [PTR_W:0] rd_ptr;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign in_ready = !((wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                      (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[PTR_W-1:0]];

  // Storage, no reset needed for the array itself
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[PTR_W-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
    end
    else if (push)
    begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_ptr <= '0;
    end
    else if (pop)
    begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : sdm_fifo

module sdm_merge #(
  parameter int NUM_CH = 4,
  parameter logic [3*32-1:0] SUPPORTED_MASKS = {3{sdm_pkg::SUPPORTED_DEFAULT}},
  parameter int FIFO_DEPTH = sdm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sdm_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [sdm_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Converter sample stream in
  input wire logic converter_sample_valid,
  output logic converter_sample_ready,
  input wire logic [NUM_CH*sdm_pkg::SAMPLE_W-1:0] converter_sample,
  // Merged sample stream out
  output logic merged_valid,
  input wire logic merged_ready,
  output logic [NUM_CH*sdm_pkg::SAMPLE_W-1:0] merged_sample,
  // Multi-purpose connector lines
  input wire logic [sdm_pkg::NUM_LINES-1:0] multi_line_in,
  output logic [sdm_pkg::NUM_LINES-1:0] multi_line_out,
  output logic [sdm_pkg::NUM_LINES-1:0] multi_line_oe_n,
  // Status
  output logic merge_active
);
  localparam int NL = sdm_pkg::NUM_LINES;
  localparam int SW = sdm_pkg::SAMPLE_W;
  localparam int DW = NUM_CH * SW;

  logic [31:0] line_function_select [NL];
  logic [31:0] applied_function [NL];
  logic [sdm_pkg::SYNC_STAGES-1:0] line_sync [NL];
  logic [NL-1:0] async_line_levels;
  logic aw_held;
  logic w_held;
  logic [sdm_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [sdm_pkg::IDX_W-1:0] wr_idx;
  logic [sdm_pkg::IDX_W-1:0] rd_idx;
  logic [31:0] wr_merged;
  logic wr_ok;
  logic apply_pulse;
  logic [DW-1:0] next_merged;

  // Map a register index to the line whose select register it is; NL means none
  function automatic int select_line(input logic [sdm_pkg::IDX_W-1:0] idx);
    if (idx == sdm_pkg::IDX_LINE0_FUNCTION_SELECT) return 0;
    if (idx == sdm_pkg::IDX_LINE1_FUNCTION_SELECT) return 1;
    if (idx == sdm_pkg::IDX_LINE2_FUNCTION_SELECT) return 2;
    return NL;
  endfunction : select_line

  // Map a register index to the line whose supported mask it is; NL means none
  function automatic int supported_line(input logic [sdm_pkg::IDX_W-1:0] idx);
    if (idx == sdm_pkg::IDX_LINE0_SUPPORTED_FUNCTIONS) return 0;
    if (idx == sdm_pkg::IDX_LINE1_SUPPORTED_FUNCTIONS) return 1;
    if (idx == sdm_pkg::IDX_LINE2_SUPPORTED_FUNCTIONS) return 2;
    return NL;
  endfunction : supported_line

  // Exactly one code, and one the line offers; zero is always allowed
  function automatic logic code_allowed(input logic [31:0] code, input logic [31:0] mask);
    logic one_hot;
    one_hot = (code & (code - 32'h00000001)) == 32'h00000000;
    return (code == sdm_pkg::FUNCTION_NONE) ||
           (one_hot && ((code & mask) != 32'h00000000));
  endfunction : code_allowed

  // Digital line feeding a channel's top bit
  function automatic int line_for_channel(input int ch);
    if (NUM_CH == 4) return ch % NL;
    return 0;
  endfunction : line_for_channel

  // Merge byte-lane strobes over the current value
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : strobe_merge

  // Pin inputs pass three flops; a level counts once the last two agree
  generate
    for (genvar i = 0; i < NL; i++)
    begin : g_line_sync
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          line_sync[i] <= '0;
        end
        else
        begin
          line_sync[i] <= {line_sync[i][sdm_pkg::SYNC_STAGES-2:0], multi_line_in[i]};
        end
      end

      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          async_line_levels[i] <= 1'b0;
        end
        else if (line_sync[i][sdm_pkg::SYNC_STAGES-1] == line_sync[i][sdm_pkg::SYNC_STAGES-2])
        begin
          async_line_levels[i] <= line_sync[i][sdm_pkg::SYNC_STAGES-1];
        end
      end
    end
  endgenerate

  // Lines are only ever inputs here, so the drivers always stay tristated
  assign multi_line_out = '0;
  assign multi_line_oe_n = '1;

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[sdm_pkg::IDX_LSB +: sdm_pkg::IDX_W];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_held <= 1'b0;
    end
  end

  // Decide whether the pending write lands
  always_comb
  begin
    wr_merged = sdm_pkg::FUNCTION_NONE;
    wr_ok = 1'b0;
    if (select_line(wr_idx) < NL)
    begin
      wr_merged = strobe_merge(line_function_select[select_line(wr_idx)], w_data, w_strb);
      wr_ok = code_allowed(wr_merged, SUPPORTED_MASKS[select_line(wr_idx)*32 +: 32]);
    end
    else if (wr_idx == sdm_pkg::IDX_CARD_COMMAND)
    begin
      wr_ok = 1'b1;
    end
  end

  // Select registers hold the software view; refused codes leave them alone
  generate
    for (genvar i = 0; i < NL; i++)
    begin : g_select
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          line_function_select[i] <= sdm_pkg::SELECT_RESET;
        end
        else if (wr_fire && wr_ok && select_line(wr_idx) == i)
        begin
          line_function_select[i] <= wr_merged;
        end
      end

      // Hardware follows a new code only on a start or setup command
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          applied_function[i] <= sdm_pkg::SELECT_RESET;
        end
        else if (apply_pulse)
        begin
          applied_function[i] <= line_function_select[i];
        end
      end
    end
  endgenerate

  // Command pulse, one cycle, issued from the card command register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      apply_pulse <= 1'b0;
    end
    else
    begin
      apply_pulse <= wr_fire && (wr_idx == sdm_pkg::IDX_CARD_COMMAND) && w_strb[0] &&
                     (w_data[sdm_pkg::CMD_CARD_START_BIT] ||
                      w_data[sdm_pkg::CMD_WRITE_SETUP_BIT]);
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdm_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? sdm_pkg::RESP_OKAY : sdm_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data registered at the address handshake
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[sdm_pkg::IDX_LSB +: sdm_pkg::IDX_W];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sdm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sdm_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      if (select_line(rd_idx) < NL)
      begin
        s_axi_rdata <= line_function_select[select_line(rd_idx)];
      end
      else if (supported_line(rd_idx) < NL)
      begin
        s_axi_rdata <= SUPPORTED_MASKS[supported_line(rd_idx)*32 +: 32];
      end
      else if (rd_idx == sdm_pkg::IDX_ASYNC_LINE_LEVELS)
      begin
        s_axi_rdata <= {{(32-NL){1'b0}}, async_line_levels};
      end
      else if (rd_idx == sdm_pkg::IDX_MERGE_STATUS)
      begin
        s_axi_rdata <= {31'h00000000, merge_active};
      end
      else if (rd_idx != sdm_pkg::IDX_CARD_COMMAND)
      begin
        s_axi_rresp <= sdm_pkg::RESP_SLVERR; // Unmapped index reads zero with an error
      end
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Any line set to digital input changes the layout of all channels
  always_comb
  begin
    merge_active = 1'b0;
    for (int i = 0; i < NL; i++)
    begin
      if (applied_function[i] == sdm_pkg::FUNCTION_SYNC_DIGITAL_IN) merge_active = 1'b1;
    end
  end

  // Build each channel byte; no sign extension, the reader masks bit 7
  always_comb
  begin
    next_merged = converter_sample;
    if (merge_active)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        next_merged[c*SW +: SW-1] = converter_sample[c*SW+sdm_pkg::ANALOG_DROP +: SW-1];
        next_merged[c*SW+sdm_pkg::DIGITAL_BIT] = async_line_levels[line_for_channel(c)];
      end
    end
  end

  // Output buffer; a full buffer stalls the converter stream
  sdm_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(converter_sample_valid),
    .in_ready(converter_sample_ready),
    .in_data(next_merged),
    .out_valid(merged_valid),
    .out_ready(merged_ready),
    .out_data(merged_sample)
  );
endmodule : sdm_merge

// *** sim/sdm_line_src.sv ***
// External digital sources driving the connector lines
`timescale 1ns/1ps
module sdm_line_src (
  // Clock
  input wire logic ref_clk,
  // Levels toward the card
  output logic [sdm_pkg::NUM_LINES-1:0] multi_line_in
);
  // Push-pull sources: the lines never float, so no idle pattern is needed
  initial multi_line_in = 3'h0;

  // New level launched right after a clock edge, like a source on the sample clock
  task automatic put(input logic [2:0] v);
    @(posedge ref_clk);
    multi_line_in <= v;
  endtask : put
endmodule : sdm_line_src

// *** sim/sdm_merge_properties.sv ***
// Port checker for the sync digital input merge block
`timescale 1ns/1ps
module sdm_merge_checker #(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Sample streams
  input wire logic converter_sample_valid,
  input wire logic converter_sample_ready,
  input wire logic [NUM_CH*sdm_pkg::SAMPLE_W-1:0] converter_sample,
  input wire logic merged_valid,
  input wire logic merged_ready,
  input wire logic [NUM_CH*sdm_pkg::SAMPLE_W-1:0] merged_sample,
  // Connector and status
  input wire logic [sdm_pkg::NUM_LINES-1:0] multi_line_out,
  input wire logic [sdm_pkg::NUM_LINES-1:0] multi_line_oe_n,
  input wire logic merge_active
);
  logic [NUM_CH*8-1:0] halved;
  logic [NUM_CH*8-1:0] low7;

  // Analog part of each byte once merging drops the converter LSB
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      halved[c*8+:8] = {1'b0, converter_sample[c*8+1+:7]};
      low7[c*8+:8] = 8'h7F;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_tristate;
    multi_line_oe_n == 3'h7 && multi_line_out == 3'h0;
  endproperty
  a_tristate: assert property (p_tristate) else $error("connector line driven");

  property p_read_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans) else $error("read not answered");

  property p_read_cause;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid);
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("read answer unasked");

  property p_stream_hold;
    merged_valid && !merged_ready |=> merged_valid && $stable(merged_sample);
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("output sample moved");

  // Full buffer can only refuse while it has something to offer
  property p_full;
    !converter_sample_ready |-> merged_valid;
  endproperty
  a_full: assert property (p_full) else $error("refused while empty");

  property p_std_pass;
    !merged_valid && converter_sample_valid && converter_sample_ready && !merge_active
      |=> merged_sample == $past(converter_sample);
  endproperty
  a_std_pass: assert property (p_std_pass) else $error("standard sample altered");

  property p_dig_shift;
    !merged_valid && converter_sample_valid && converter_sample_ready && merge_active
      |=> (merged_sample & low7) == $past(halved);
  endproperty
  a_dig_shift: assert property (p_dig_shift) else $error("analog bits misplaced");

  // Applied function only moves around a command write
  property p_apply;
    $changed(merge_active) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_apply: assert property (p_apply) else $error("merge changed without command");
endmodule : sdm_merge_checker

bind sdm_merge sdm_merge_checker #(.NUM_CH(NUM_CH)) i_chk (
  .ref_clk, .reset, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .converter_sample_valid, .converter_sample_ready, .converter_sample,
  .merged_valid, .merged_ready, .merged_sample,
  .multi_line_out, .multi_line_oe_n, .merge_active
);

// *** sim/sdm_merge_tb_top.sv ***
// Self-checking bench for the sync digital input merge block
`timescale 1ns/1ps
module sdm_merge_tb_top;
  // Bench-driven inputs
  logic ref_clk, reset, awvalid, wvalid, arvalid, cs_valid, m_ready, bready, rready;
  logic [3:0] strb;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, cs, rd, dd;
  logic [1:0] rs;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid, cs_ready, m_valid, merge;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, m_data;
  logic [2:0] line_in, line_out, oe_n;
  // Bookkeeping
  int n_errors, compares;
  logic [31:0] q[$];

  sdm_merge i_dut (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .converter_sample_valid(cs_valid), .converter_sample_ready(cs_ready),
    .converter_sample(cs), .merged_valid(m_valid), .merged_ready(m_ready),
    .merged_sample(m_data), .multi_line_in(line_in), .multi_line_out(line_out),
    .multi_line_oe_n(oe_n), .merge_active(merge)
  );

  sdm_line_src i_src (.ref_clk(ref_clk), .multi_line_in(line_in));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Collect delivered samples; negedge avoids racing the design's edge updates
  always @(negedge ref_clk)
    if (!reset && m_valid === 1'b1 && m_ready) q.push_back(m_data);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function logic [17:0] ad(input logic [15:0] i);
    return {i, 2'h0};
  endfunction : ad

  // Expected merged word: line level on top, converter LSB dropped
  function logic [31:0] mx(input logic [31:0] s, input logic [2:0] l);
    for (int c = 0; c < 4; c++) mx[c*8+:8] = {l[c%3], s[c*8+1+:7]};
  endfunction : mx

  // Write: both halves offered together, each released when taken
  task wchk(input logic [15:0] i, input logic [31:0] d, input logic [1:0] r);
    logic a, w, b;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= ad(i);
    wdata <= d;
    do
    begin
      #1;
      a = awready;
      w = wready;
      b = bvalid;
      rs = bresp;
      @(posedge ref_clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (b !== 1'b1);
    // Response taken; one idle edge keeps the next call from reassigning bready at once
    bready <= 1'b0;
    @(posedge ref_clk);
    chk({30'h0, rs}, {30'h0, r});
  endtask : wchk

  task rchk(input logic [15:0] i, input logic [31:0] e, input logic [1:0] r);
    logic a, v;
    arvalid <= 1'b1;
    araddr <= ad(i);
    rready <= 1'b1;
    do
    begin
      #1;
      a = arready;
      v = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge ref_clk);
      if (a) arvalid <= 1'b0;
    end while (v !== 1'b1);
    rready <= 1'b0;
    @(posedge ref_clk);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, r});
  endtask : rchk

  // Valid stays up so back-to-back pushes need no gap
  task push(input logic [31:0] d);
    logic k;
    cs_valid <= 1'b1;
    cs <= d;
    do
    begin
      #1;
      k = cs_ready;
      @(posedge ref_clk);
    end while (k !== 1'b1);
  endtask : push

  task pop(output logic [31:0] d);
    for (int n = 0; n < 50 && q.size() == 0; n++) @(posedge ref_clk);
    d = (q.size() > 0) ? q.pop_front() : 32'hX;
  endtask : pop

  task samp(input logic [31:0] s, input logic [31:0] e);
    push(s);
    cs_valid <= 1'b0;
    pop(dd);
    chk(dd, e);
  endtask : samp

  task wrap_up;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    reset = 1'b1;
    {awvalid, wvalid, arvalid, cs_valid, m_ready, bready, rready} = 7'h04;
    strb = 4'hF;
    awaddr = 18'h0;
    araddr = 18'h0;
    wdata = 32'h0;
    cs = 32'h0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int k = 0; k < 3; k++)
    begin
      rchk(sdm_pkg::IDX_LINE0_FUNCTION_SELECT + k[15:0], 32'h0, sdm_pkg::RESP_OKAY);
      rchk(sdm_pkg::IDX_LINE0_SUPPORTED_FUNCTIONS + k[15:0], 32'h4, sdm_pkg::RESP_OKAY);
    end
    chk({29'h0, oe_n}, 32'h7);
    chk({29'h0, line_out}, 32'h0);
    wchk(sdm_pkg::IDX_LINE0_SUPPORTED_FUNCTIONS, 32'h0, sdm_pkg::RESP_SLVERR);
    rchk(sdm_pkg::IDX_LINE0_SUPPORTED_FUNCTIONS, 32'h4, sdm_pkg::RESP_OKAY);
    rchk(16'h0100, 32'h0, sdm_pkg::RESP_SLVERR);
    // Unsupported and combined codes are refused
    wchk(sdm_pkg::IDX_LINE0_FUNCTION_SELECT, 32'h2, sdm_pkg::RESP_SLVERR);
    wchk(sdm_pkg::IDX_LINE0_FUNCTION_SELECT, 32'h6, sdm_pkg::RESP_SLVERR);
    // Byte strobes merge over the old code before it is judged
    strb <= 4'h2;
    wchk(sdm_pkg::IDX_LINE0_FUNCTION_SELECT, 32'h00000404, sdm_pkg::RESP_SLVERR);
    strb <= 4'h1;
    wchk(sdm_pkg::IDX_LINE2_FUNCTION_SELECT, 32'h0000FF04, sdm_pkg::RESP_OKAY);
    strb <= 4'hF;
    rchk(sdm_pkg::IDX_LINE2_FUNCTION_SELECT, 32'h4, sdm_pkg::RESP_OKAY);
    rchk(sdm_pkg::IDX_LINE0_FUNCTION_SELECT, 32'h0, sdm_pkg::RESP_OKAY);
    // Selected but not applied yet: samples stay standard
    i_src.put(3'h7);
    wchk(sdm_pkg::IDX_LINE1_FUNCTION_SELECT, 32'h4, sdm_pkg::RESP_OKAY);
    rchk(sdm_pkg::IDX_LINE1_FUNCTION_SELECT, 32'h4, sdm_pkg::RESP_OKAY);
    samp(32'h807F01FE, 32'h807F01FE);
    wchk(sdm_pkg::IDX_CARD_COMMAND, 32'h2, sdm_pkg::RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, merge}, 32'h1);
    rchk(sdm_pkg::IDX_MERGE_STATUS, 32'h1, sdm_pkg::RESP_OKAY);
    // Merged layout, every channel and its line
    i_src.put(3'h5);
    repeat (6) @(posedge ref_clk);
    rchk(sdm_pkg::IDX_ASYNC_LINE_LEVELS, 32'h5, sdm_pkg::RESP_OKAY);
    samp(32'h807F01FE, mx(32'h807F01FE, 3'h5));
    i_src.put(3'h2);
    repeat (6) @(posedge ref_clk);
    samp(32'h00FF8033, mx(32'h00FF8033, 3'h2));
    chk(dd & 32'h7F7F7F7F, 32'h007F4019);
    // Back to no function, applied by card start
    wchk(sdm_pkg::IDX_LINE1_FUNCTION_SELECT, 32'h0, sdm_pkg::RESP_OKAY);
    wchk(sdm_pkg::IDX_LINE2_FUNCTION_SELECT, 32'h0, sdm_pkg::RESP_OKAY);
    chk({31'h0, merge}, 32'h1);
    wchk(sdm_pkg::IDX_CARD_COMMAND, 32'h1, sdm_pkg::RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, merge}, 32'h0);
    // Fill the buffer with the reader stalled, then drain in order
    m_ready <= 1'b0;
    for (int k = 0; k < 32; k++) push({k[7:0], 16'h807F, k[7:0]});
    cs_valid <= 1'b0;
    #1;
    chk({31'h0, cs_ready}, 32'h0);
    @(posedge ref_clk);
    m_ready <= 1'b1;
    for (int k = 0; k < 32; k++)
    begin
      pop(dd);
      chk(dd, {k[7:0], 16'h807F, k[7:0]});
    end
    wrap_up;
  end

  // Watchdog: the sequence needs well under 2,000 cycles
  initial
  begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule : sdm_merge_tb_top
